// ---- rtl/dcf_mailbox_fifo.sv ----
// Two-port FIFO with bypass mailboxes, parity check and generation
`timescale 1ns/10ps
module dcf_mailbox_fifo #(
  parameter int DEPTH = dcf_pkg::FIFO_DEPTH
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    device_reset_n,
  input  wire logic                    offset_select_low,
  input  wire logic                    offset_select_high,
  input  wire logic                    parity_odd_sel,
  input  wire dcf_pkg::dcf_port_ctrl_t port_a_ctrl,
  input  wire dcf_pkg::dcf_word_t      port_a_data_in,
  output dcf_pkg::dcf_word_t           port_a_data_out,
  output logic                         port_a_data_oe,
  output logic                         port_a_parity_error_n,
  input  wire dcf_pkg::dcf_port_ctrl_t port_b_ctrl,
  input  wire dcf_pkg::dcf_word_t      port_b_data_in,
  output dcf_pkg::dcf_word_t           port_b_data_out,
  output logic                         port_b_data_oe,
  output logic                         port_b_parity_error_n,
  output logic                         full_flag_n,
  output logic                         empty_flag_n,
  output logic                         almost_full_flag_n,
  output logic                         almost_empty_flag_n,
  output logic                         forward_mail_flag_n,
  output logic                         return_mail_flag_n
);
  import dcf_pkg::*;

  // Reset pin synchroniser and the device reset it produces
  logic [SYNC_STAGES-1:0] rst_sync_r;     // Shift chain, bit 0 sees the pin
  logic                   rst_level_r;    // Agreed pin level, high released
  logic                   dev_reset;      // Internal reset of FIFO, flags, settle count and port-B register
  logic [1:0]             settle_r;       // Edges counted since release
  logic [LEVEL_W-1:0]     offset_r;       // Almost-flag offset

  // Mailboxes and their flags
  dcf_word_t forward_mailbox_r;           // Port A to port B
  dcf_word_t return_mailbox_r;            // Port B to port A
  logic      forward_flag_r;              // Low while mail is waiting
  logic      return_flag_r;               // Low while mail is waiting

  // FIFO side signals
  dcf_word_t          fifo_out;           // Word at the head
  logic               fifo_in_ready;      // Room for a word
  logic               fifo_out_valid;     // A word waits
  logic [LEVEL_W-1:0] fifo_level;         // Words held
  dcf_word_t          out_reg_r;          // Port-B FIFO output register

  // Decoded port operations for this edge
  logic a_active;                         // Port A qualified edge
  logic b_active;                         // Port B qualified edge
  logic a_fifo_write;
  logic a_mail_write;
  logic a_mail_read;
  logic b_fifo_read;
  logic b_mail_write;
  logic b_mail_read;
  logic a_drive;                          // Port A outputs on
  logic b_drive;                          // Port B outputs on
  dcf_word_t a_next_data;                 // Port A word to show
  dcf_word_t b_next_data;                 // Port B word to show
  logic a_err_next;                       // Port A check result
  logic b_err_next;                       // Port B check result

  // Pin chain; the first flop feeds only the second
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rst_sync_r <= '0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], device_reset_n};
    end
  end

  // Pin level changes only once the last two stages agree
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rst_level_r <= 1'b0;
    end
    else if (rst_sync_r[SYNC_STAGES-1] == rst_sync_r[SYNC_STAGES-2])
    begin
      rst_level_r <= rst_sync_r[SYNC_STAGES-1];
    end
  end

  // Held low for a few edges so the chain always sees it
  assign dev_reset = reset || !rst_level_r;

  // Offset captured on the release edge of the pin
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      offset_r <= OFFSET_SEL_00;
    end
    else if (!rst_level_r && rst_sync_r[SYNC_STAGES-1] && rst_sync_r[SYNC_STAGES-2])
    begin
      unique case ({offset_select_high, offset_select_low})
        2'b11: offset_r <= OFFSET_SEL_11;
        2'b10: offset_r <= OFFSET_SEL_10;
        2'b01: offset_r <= OFFSET_SEL_01;
        2'b00: offset_r <= OFFSET_SEL_00;
      endcase
    end
  end

  // Count edges after release before the full flag may rise
  always_ff @(posedge clock)
  begin
    if (dev_reset)
    begin
      settle_r <= '0;
    end
    else if (settle_r != 2'(FULL_SETTLE))
    begin
      settle_r <= settle_r + 1'b1;
    end
  end

  // Decode of the function tables; enable low means nothing happens
  assign a_active     = !port_a_ctrl.select_n && port_a_ctrl.enable;
  assign b_active     = !port_b_ctrl.select_n && port_b_ctrl.enable;
  assign a_fifo_write = a_active && port_a_ctrl.write_read_sel && !port_a_ctrl.mailbox_sel
                        && full_flag_n && !dev_reset;
  assign a_mail_write = a_active && port_a_ctrl.write_read_sel && port_a_ctrl.mailbox_sel
                        && forward_flag_r;
  assign a_mail_read  = a_active && !port_a_ctrl.write_read_sel && port_a_ctrl.mailbox_sel;
  // Port-B write with mailbox select low falls through to nothing
  assign b_mail_write = b_active && port_b_ctrl.write_read_sel && port_b_ctrl.mailbox_sel
                        && return_flag_r;
  assign b_mail_read  = b_active && !port_b_ctrl.write_read_sel && port_b_ctrl.mailbox_sel;
  assign b_fifo_read  = b_active && !port_b_ctrl.write_read_sel && !port_b_ctrl.mailbox_sel
                        && empty_flag_n && !dev_reset;

  // Buffer between the ports; its level drives the flags
  dcf_word_fifo #(
    .WIDTH   (DATA_W),
    .DEPTH   (DEPTH),
    .LEVEL_W (LEVEL_W)
  ) u_fifo (
    .clock     (clock),
    .reset     (dev_reset),
    .in_valid  (a_fifo_write),
    .in_ready  (fifo_in_ready),
    .in_data   (port_a_data_in),
    .out_valid (fifo_out_valid),
    .out_ready (b_fifo_read),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // Port-B output register loads the head word on a FIFO read
  always_ff @(posedge clock)
  begin
    if (dev_reset)
    begin
      out_reg_r <= '0;
    end
    else if (b_fifo_read)
    begin
      out_reg_r <= fifo_out;
    end
  end

  // Forward mailbox written from port A, kept after reads
  always_ff @(posedge clock)
  begin
    if (a_mail_write)
    begin
      forward_mailbox_r <= port_a_data_in;
    end
  end

  // Return mailbox written from port B, kept after reads
  always_ff @(posedge clock)
  begin
    if (b_mail_write)
    begin
      return_mailbox_r <= port_b_data_in;
    end
  end

  // Forward flag; new mail wins over a read in the same edge
  always_ff @(posedge clock)
  begin
    if (dev_reset)
    begin
      forward_flag_r <= FLAG_RESET_MAIL_N;
    end
    else if (a_mail_write)
    begin
      forward_flag_r <= 1'b0;
    end
    else if (b_mail_read)
    begin
      forward_flag_r <= 1'b1;
    end
  end

  // Return flag; same priority as the forward one
  always_ff @(posedge clock)
  begin
    if (dev_reset)
    begin
      return_flag_r <= FLAG_RESET_MAIL_N;
    end
    else if (b_mail_write)
    begin
      return_flag_r <= 1'b0;
    end
    else if (a_mail_read)
    begin
      return_flag_r <= 1'b1;
    end
  end

  assign forward_mail_flag_n = forward_flag_r;
  assign return_mail_flag_n  = return_flag_r;

  // FIFO status flags, low active, registered from the level
  always_ff @(posedge clock)
  begin
    if (dev_reset)
    begin
      full_flag_n         <= FLAG_RESET_FULL_N;
      empty_flag_n        <= FLAG_RESET_EMPTY_N;
      almost_full_flag_n  <= FLAG_RESET_AFULL_N;
      almost_empty_flag_n <= FLAG_RESET_AEMPTY_N;
    end
    else
    begin
      // Room shows only once the settle count is done
      full_flag_n         <= (settle_r >= 2'(FULL_SETTLE - 1)) && (fifo_level < LEVEL_W'(DEPTH - 1)
                             || (fifo_level == LEVEL_W'(DEPTH - 1) && !a_fifo_write)
                             || b_fifo_read);
      empty_flag_n        <= fifo_out_valid && !(b_fifo_read && fifo_level == LEVEL_W'(1))
                             || a_fifo_write && fifo_level == '0 && !b_fifo_read;
      almost_full_flag_n  <= fifo_level < LEVEL_W'(DEPTH) - offset_r;
      almost_empty_flag_n <= fifo_level > offset_r;
    end
  end

  // Drive windows: select and read both low; enable plays no part, and the output flops delay them one clock
  assign a_drive = !port_a_ctrl.select_n && !port_a_ctrl.write_read_sel;
  assign b_drive = !port_b_ctrl.select_n && !port_b_ctrl.write_read_sel;

  // Port A always shows the return mailbox, parity filled on request
  assign a_next_data = port_a_ctrl.parity_generate ?
                       dcf_parity_fill(return_mailbox_r, parity_odd_sel) : return_mailbox_r;

  // Port B shows the output register or the forward mailbox
  always_comb
  begin
    b_next_data = port_b_ctrl.mailbox_sel ? forward_mailbox_r : out_reg_r;
    if (port_b_ctrl.parity_generate)
    begin
      b_next_data = dcf_parity_fill(b_next_data, parity_odd_sel);
    end
  end

  // Parity trees are shared with generation, so a generating mailbox read masks the check
  assign a_err_next = dcf_parity_fail(port_a_data_in, parity_odd_sel)
                      && !(a_mail_read && port_a_ctrl.parity_generate);
  assign b_err_next = dcf_parity_fail(port_b_data_in, parity_odd_sel)
                      && !(b_mail_read && port_b_ctrl.parity_generate);

  // Output flops; one cycle behind the pins to keep outputs registered
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      port_a_data_out       <= '0;
      port_a_data_oe        <= 1'b0;
      port_b_data_out       <= '0;
      port_b_data_oe        <= 1'b0;
      port_a_parity_error_n <= 1'b1;
      port_b_parity_error_n <= 1'b1;
    end
    else
    begin
      port_a_data_out       <= a_next_data;
      port_a_data_oe        <= a_drive;
      port_b_data_out       <= b_next_data;
      port_b_data_oe        <= b_drive;
      port_a_parity_error_n <= !a_err_next;
      port_b_parity_error_n <= !b_err_next;
    end
  end

endmodule

// ---- inc/dcf_pkg.sv ----
// Constants, carrier types and helpers for the dual-port FIFO with mailboxes
package dcf_pkg;

  localparam int DATA_W      = 36;          // Word width of both ports
  localparam int BYTE_W      = 9;           // Eight data bits and one parity bit
  localparam int BYTE_N      = 4;           // Bytes per word
  localparam int FIFO_DEPTH  = 64;          // Words held in the FIFO
  localparam int LEVEL_W     = 7;           // Enough bits to count 0..64
  localparam int SYNC_STAGES = 3;           // Flops on an outside pin
  localparam int FULL_SETTLE = 2;           // Edges after release before room shows

  // Almost-flag offsets picked by the two select pins at reset release
  localparam logic [LEVEL_W-1:0] OFFSET_SEL_11 = 7'h10;
  localparam logic [LEVEL_W-1:0] OFFSET_SEL_10 = 7'h0c;
  localparam logic [LEVEL_W-1:0] OFFSET_SEL_01 = 7'h08;
  localparam logic [LEVEL_W-1:0] OFFSET_SEL_00 = 7'h04;

  // Reset values of the low-active flags
  localparam logic FLAG_RESET_FULL_N   = 1'b0;
  localparam logic FLAG_RESET_EMPTY_N  = 1'b0;
  localparam logic FLAG_RESET_AEMPTY_N = 1'b0;
  localparam logic FLAG_RESET_AFULL_N  = 1'b1;
  localparam logic FLAG_RESET_MAIL_N   = 1'b1;

  typedef logic [DATA_W-1:0] dcf_word_t;    // One port word

  // Control pins of one port, grouped as they travel together
  typedef struct packed {
    logic select_n;          // Chip select, low active
    logic write_read_sel;    // High write, low read
    logic enable;            // Qualifies the clock edge
    logic mailbox_sel;       // High picks a mailbox
    logic parity_generate;   // Replace parity bits on reads
  } dcf_port_ctrl_t;

  // Byte parity check: high when any byte fails the selected sense
  function automatic logic dcf_parity_fail(input dcf_word_t w, input logic odd);
    logic fail;
    fail = 1'b0;
    for (int i = 0; i < BYTE_N; i++)
    begin
      fail = fail | ((^w[i*BYTE_W +: BYTE_W]) != odd);
    end
    return fail;
  endfunction

  // Replace the top bit of each byte with generated parity
  function automatic dcf_word_t dcf_parity_fill(input dcf_word_t w, input logic odd);
    dcf_word_t r;
    r = w;
    for (int i = 0; i < BYTE_N; i++)
    begin
      r[i*BYTE_W + BYTE_W - 1] = (^w[i*BYTE_W +: BYTE_W-1]) ^ odd;
    end
    return r;
  endfunction

endpackage

// ---- rtl/dcf_word_fifo.sv ----
// Word FIFO with valid/ready on both sides and a fill level
`timescale 1ns/10ps
module dcf_word_fifo #(
  parameter int WIDTH   = 36,
  parameter int DEPTH   = 64,
  parameter int LEVEL_W = 7
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire logic [WIDTH-1:0]   in_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [WIDTH-1:0]        out_data,
  output logic [LEVEL_W-1:0]      level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0]   mem [DEPTH];   // Storage array
  logic [PTR_W-1:0]   wr_ptr_r;      // Next slot to fill
  logic [PTR_W-1:0]   rd_ptr_r;      // Oldest word
  logic [LEVEL_W-1:0] level_r;       // Words held
  logic               push;          // Accepted write
  logic               pop;           // Accepted read

  // Full and empty come straight from the level, so they never lie
  assign in_ready  = (level_r != LEVEL_W'(DEPTH));
  assign out_valid = (level_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];
  assign level     = level_r;

  // Memory write, no reset needed on data
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap; depth is a power of two by default
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Level tracks both sides in one place
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      level_r <= '0;
    end
    else if (push && !pop)
    begin
      level_r <= level_r + 1'b1;
    end
    else if (pop && !push)
    begin
      level_r <= level_r - 1'b1;
    end
  end

endmodule

// ---- verif/dcf_mailbox_fifo_chk.sv ----
// Concurrent checks on the pins of the mailbox FIFO
`timescale 1ns/10ps
module dcf_mailbox_fifo_chk (
  input wire logic                    clock,
  input wire logic                    reset,
  input wire logic                    device_reset_n,
  input wire logic                    parity_odd_sel,
  input wire dcf_pkg::dcf_port_ctrl_t port_a_ctrl,
  input wire dcf_pkg::dcf_port_ctrl_t port_b_ctrl,
  input wire dcf_pkg::dcf_word_t      port_b_data_in,
  input wire logic                    port_a_data_oe,
  input wire logic                    port_b_data_oe,
  input wire logic                    port_b_parity_error_n,
  input wire logic                    full_flag_n,
  input wire logic                    empty_flag_n,
  input wire logic                    almost_full_flag_n,
  input wire logic                    almost_empty_flag_n,
  input wire logic                    forward_mail_flag_n,
  input wire logic                    return_mail_flag_n
);
  import dcf_pkg::*;
  logic [3:0] live_cnt_r;  // Cycles since the reset pin went high
  logic [3:0] low_cnt_r;   // Cycles the reset pin has been low
  logic       live;        // Internal reset surely over
  logic       bad_b;       // Some port-B byte fails parity
  logic       a_act, b_act, a_mwr, a_mrd, a_fwr, b_mwr, b_mrd;
  assign live  = (live_cnt_r == 4'hf);
  assign a_act = !port_a_ctrl.select_n && !port_a_ctrl.write_read_sel;
  assign b_act = !port_b_ctrl.select_n && !port_b_ctrl.write_read_sel;
  // Enabled accesses decoded per port
  assign a_fwr = !port_a_ctrl.select_n && port_a_ctrl.write_read_sel && port_a_ctrl.enable && !port_a_ctrl.mailbox_sel;
  assign a_mwr = !port_a_ctrl.select_n && port_a_ctrl.write_read_sel && port_a_ctrl.enable && port_a_ctrl.mailbox_sel;
  assign a_mrd = a_act && port_a_ctrl.enable && port_a_ctrl.mailbox_sel;
  assign b_mwr = !port_b_ctrl.select_n && port_b_ctrl.write_read_sel && port_b_ctrl.enable && port_b_ctrl.mailbox_sel;
  assign b_mrd = b_act && port_b_ctrl.enable && port_b_ctrl.mailbox_sel;
  // Byte parity of the port-B bus, worked out here on its own
  always_comb
  begin
    bad_b = 1'h0;
    for (int i = 0; i < 4; i++)
      bad_b = bad_b | ((^port_b_data_in[i*9 +: 9]) != parity_odd_sel);
  end
  // Settle counter; generous, since the pin passes a synchroniser
  always_ff @(posedge clock)
  begin
    if (reset || !device_reset_n)
      live_cnt_r <= 4'h0;
    else if (!live)
      live_cnt_r <= live_cnt_r + 4'h1;
  end
  // Length of the low phase of the reset pin, saturating
  always_ff @(posedge clock)
  begin
    if (reset || device_reset_n)
      low_cnt_r <= 4'h0;
    else if (low_cnt_r != 4'hf)
      low_cnt_r <= low_cnt_r + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence fwd_write; live && a_mwr && forward_mail_flag_n; endsequence
  sequence fwd_read; live && b_mrd && !a_mwr; endsequence
  sequence ret_write; live && b_mwr && return_mail_flag_n; endsequence
  sequence ret_read; live && a_mrd && !b_mwr; endsequence
  a_oe_port_a: assert property (!$past(reset) |-> port_a_data_oe == $past(a_act))
    else $error("port A enable does not follow selects");
  a_oe_port_b: assert property (!$past(reset) |-> port_b_data_oe == $past(b_act))
    else $error("port B enable does not follow selects");
  a_fwd_mail_set: assert property (fwd_write |=> !forward_mail_flag_n)
    else $error("forward mail flag not set by write");
  a_fwd_mail_clear: assert property (fwd_read |=> forward_mail_flag_n)
    else $error("forward mail flag not cleared by read");
  a_ret_mail_set: assert property (ret_write |=> !return_mail_flag_n)
    else $error("return mail flag not set by write");
  a_ret_mail_clear: assert property (ret_read |=> return_mail_flag_n)
    else $error("return mail flag not cleared by read");
  a_parity_b_check: assert property (live && !(b_mrd && port_b_ctrl.parity_generate)
    |=> port_b_parity_error_n == !$past(bad_b))
    else $error("port B parity error wrong");
  a_parity_b_forced: assert property (live && b_mrd && port_b_ctrl.parity_generate |=> port_b_parity_error_n)
    else $error("port B parity error not forced high");
  a_reset_flag_levels: assert property (!device_reset_n [*8] |-> !full_flag_n && !empty_flag_n
    && !almost_empty_flag_n && almost_full_flag_n && forward_mail_flag_n && return_mail_flag_n)
    else $error("flag levels wrong in reset");
  a_empty_after_write: assert property (live && a_fwr && full_flag_n |-> ##[1:2] empty_flag_n)
    else $error("write did not clear empty");
  a_full_after_release: assert property (device_reset_n && low_cnt_r == 4'hf
    |-> !full_flag_n [*3] ##[1:8] full_flag_n)
    else $error("full flag timing after reset wrong");
endmodule
bind dcf_mailbox_fifo dcf_mailbox_fifo_chk dcf_mailbox_fifo_chk_i (.clock, .reset, .device_reset_n,
  .parity_odd_sel, .port_a_ctrl, .port_b_ctrl, .port_b_data_in, .port_a_data_oe, .port_b_data_oe,
  .port_b_parity_error_n, .full_flag_n, .empty_flag_n, .almost_full_flag_n, .almost_empty_flag_n,
  .forward_mail_flag_n, .return_mail_flag_n);

// ---- verif/dcf_port_host.sv ----
// Bus controller model standing on one port of the mailbox FIFO
`timescale 1ns/10ps
module dcf_port_host (
  input  wire logic               clock,
  output dcf_pkg::dcf_port_ctrl_t ctrl,
  output dcf_pkg::dcf_word_t      wire_data,
  input  wire dcf_pkg::dcf_word_t data_out,
  input  wire logic               data_oe
);
  import dcf_pkg::*;
  dcf_word_t drive_r;  // Word driven while writing
  dcf_word_t last_r;   // Last bus level seen
  // Nobody driving: inverse of last level, so a stale word never passes
  assign wire_data = data_oe ? data_out : (ctrl.write_read_sel ? drive_r : ~last_r);
  initial
  begin
    ctrl    = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
    drive_r = 36'h0;
  end
  // Bus history for the released state
  always @(posedge clock)
    last_r <= wire_data;
  // Set up with enable low first, so direction settles before the edge
  task automatic op(input logic wr, input logic mb, input logic pg, input dcf_word_t d);
    @(posedge clock);
    ctrl    <= '{1'h0, wr, 1'h0, mb, pg};
    drive_r <= d;
    @(posedge clock);
    ctrl.enable <= 1'h1;
    @(posedge clock);
    ctrl.enable <= 1'h0;
  endtask
  // Deselected, driving a word for the parity trees
  task automatic idle(input dcf_word_t d);
    @(posedge clock);
    ctrl    <= '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
    drive_r <= d;
  endtask
endmodule

// ---- verif/dcf_mailbox_fifo_test.sv ----
// Self-checking bench for the mailbox FIFO
`timescale 1ns/10ps
module dcf_mailbox_fifo_test;
  import dcf_pkg::*;
  logic clock, reset, device_reset_n, offset_select_low, offset_select_high, parity_odd_sel;
  dcf_port_ctrl_t port_a_ctrl, port_b_ctrl;
  dcf_word_t a_bus, b_bus, port_a_data_out, port_b_data_out, w, w1, last_w;
  logic port_a_data_oe, port_b_data_oe, port_a_parity_error_n, port_b_parity_error_n, full_flag_n, empty_flag_n;
  logic almost_full_flag_n, almost_empty_flag_n, forward_mail_flag_n, return_mail_flag_n, odd;
  int errors, n_compared;
  dcf_word_t q[$];  // Words expected out of the FIFO
  dcf_mailbox_fifo dcf_mailbox_fifo_i (.clock, .reset, .device_reset_n, .offset_select_low, .offset_select_high,
    .parity_odd_sel, .port_a_ctrl, .port_a_data_in(a_bus), .port_a_data_out, .port_a_data_oe,
    .port_a_parity_error_n, .port_b_ctrl, .port_b_data_in(b_bus), .port_b_data_out, .port_b_data_oe,
    .port_b_parity_error_n, .full_flag_n, .empty_flag_n, .almost_full_flag_n, .almost_empty_flag_n,
    .forward_mail_flag_n, .return_mail_flag_n);
  dcf_port_host dcf_port_host_a_i (.clock, .ctrl(port_a_ctrl), .wire_data(a_bus), .data_out(port_a_data_out),
    .data_oe(port_a_data_oe));
  dcf_port_host dcf_port_host_b_i (.clock, .ctrl(port_b_ctrl), .wire_data(b_bus), .data_out(port_b_data_out),
    .data_oe(port_b_data_oe));
  initial
  begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  function automatic dcf_word_t rnd();
    rnd = {4'($urandom()), $urandom()};
  endfunction
  // Expected error: a 9-bit byte with the wrong count of ones
  function automatic logic exp_fail(input dcf_word_t v, input logic o);
    exp_fail = 1'h0;
    for (int i = 0; i < 4; i++)
      exp_fail = exp_fail | ((^v[i*9 +: 9]) != o);
  endfunction
  // Expected read word with generated parity in bit 8 of each byte
  function automatic dcf_word_t exp_fill(input dcf_word_t v, input logic o);
    exp_fill = v;
    for (int i = 0; i < 4; i++)
      exp_fill[i*9+8] = (^v[i*9 +: 8]) ^ o;
  endfunction
  task automatic chk_word(input dcf_word_t got, input dcf_word_t exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Pin reset with offset code, long enough for the synchroniser
  task automatic dev_reset(input logic hi, input logic lo);
    int k;
    @(posedge clock);
    device_reset_n     <= 1'h0;
    offset_select_high <= hi;
    offset_select_low  <= lo;
    repeat (16) @(posedge clock);
    #1;
    chk_word(36'({full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n, forward_mail_flag_n,
      return_mail_flag_n}), 36'h7, "reset flags");
    @(posedge clock);
    device_reset_n <= 1'h1;
    k = 0;
    while (full_flag_n !== 1'h1 && k < 12)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    chk_flag(full_flag_n, 1'h1, "full after reset");
    q.delete();
  endtask
  // Write a random word; kept only when room was shown
  task automatic fifo_write();
    w = rnd();
    if (full_flag_n === 1'h1)
      q.push_back(w);
    dcf_port_host_a_i.op(1'h1, 1'h0, 1'h0, w);
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Read with random parity sense and generation; empty leaves old word
  task automatic fifo_read();
    logic pg;
    pg = 1'($urandom());
    odd = 1'($urandom());
    if (empty_flag_n === 1'h1)
      last_w = q.pop_front();
    @(posedge clock);
    parity_odd_sel <= odd;
    dcf_port_host_b_i.op(1'h0, 1'h0, pg, 36'h0);
    repeat (2) @(posedge clock);
    #1;
    chk_word(b_bus, pg ? exp_fill(last_w, odd) : last_w, "fifo read");
  endtask
  // Mailbox read on port B (forward) or port A (return)
  task automatic mail_read(input logic on_b, input logic pg, input dcf_word_t v);
    odd = 1'($urandom());
    @(posedge clock);
    parity_odd_sel <= odd;
    if (on_b)
      dcf_port_host_b_i.op(1'h0, 1'h1, pg, 36'h0);
    else
      dcf_port_host_a_i.op(1'h0, 1'h1, pg, 36'h0);
    repeat (2) @(posedge clock);
    #1;
    chk_word(on_b ? b_bus : a_bus, pg ? exp_fill(v, odd) : v, "mail read");
    chk_flag(on_b ? forward_mail_flag_n : return_mail_flag_n, 1'h1, "mail flag");
  endtask
  // Cuts a hang short
  initial
  begin
    #(20 * 30000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
  initial
  begin
    reset = 1'h1;
    device_reset_n = 1'h0;
    offset_select_low = 1'h0;
    offset_select_high = 1'h0;
    parity_odd_sel = 1'h0;
    errors = 0;
    n_compared = 0;
    void'($urandom(32'h30d2));
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    // Every offset code: X words keep almost-empty low, X+1 lift it
    for (int i = 0; i < 4; i++)
    begin
      dev_reset(i[1], i[0]);
      repeat (4 + 4 * i) fifo_write();
      chk_flag(almost_empty_flag_n, 1'h0, "almost empty at X");
      fifo_write();
      chk_flag(almost_empty_flag_n, 1'h1, "almost empty at X+1");
      $display("offset code %0d done", i);
    end
    // Fill until refused, then drain past empty
    while (full_flag_n === 1'h1 && q.size() < 70)
      fifo_write();
    chk_word(36'(q.size()), 36'h40, "capacity");
    chk_flag(almost_full_flag_n, 1'h0, "almost full at full");
    fifo_write();
    while (q.size() > 0)
      fifo_read();
    chk_flag(empty_flag_n, 1'h0, "drained");
    fifo_read();
    $display("fill and drain done");
    // Mailboxes: second forward write refused, port-B FIFO write ignored, content kept after reads
    w1 = rnd();
    dcf_port_host_a_i.op(1'h1, 1'h1, 1'h0, w1);
    repeat (2) @(posedge clock);
    #1;
    chk_flag(forward_mail_flag_n, 1'h0, "forward mail set");
    dcf_port_host_a_i.op(1'h1, 1'h1, 1'h0, rnd());
    mail_read(1'h1, 1'h0, w1);
    mail_read(1'h1, 1'h1, w1);
    w1 = rnd();
    dcf_port_host_b_i.op(1'h1, 1'h1, 1'h0, w1);
    repeat (2) @(posedge clock);
    #1;
    chk_flag(return_mail_flag_n, 1'h0, "return mail set");
    dcf_port_host_b_i.op(1'h1, 1'h0, 1'h0, rnd());
    repeat (2) @(posedge clock);
    #1;
    chk_flag(empty_flag_n, 1'h0, "port B fifo write ignored");
    mail_read(1'h0, 1'h1, w1);
    mail_read(1'h0, 1'h0, w1);
    $display("mailboxes done");
    // Parity check: each byte bad in turn, clean words, then random
    for (int i = 0; i < 40; i++)
    begin
      odd = (i < 4) ? 1'h1 : 1'($urandom());
      w = rnd();
      if (i < 8)
        w = exp_fill(w, odd) ^ ((i < 4) ? (36'h100 << (9 * i)) : 36'h0);
      dcf_port_host_b_i.idle(w);
      dcf_port_host_a_i.idle(w);
      parity_odd_sel <= odd;
      repeat (2) @(posedge clock);
      #1;
      chk_flag(port_b_parity_error_n, !exp_fail(w, odd), "parity flag");
      chk_flag(port_a_parity_error_n, !exp_fail(w, odd), "port A parity flag");
    end
    $display("parity done");
    test_done();
  end
endmodule
